// file: hdl/dmacc_consts.svh
`ifndef DMACC_CONSTS_SVH
`define DMACC_CONSTS_SVH

// Register map: channel in paddr[5:4], register in paddr[3:2]
`define DMACC_CH_LSB 4
`define DMACC_REG_LSB 2
`define DMACC_MAP_TOP 6
`define DMACC_REG_MADDR 2'h0
`define DMACC_REG_IOADDR 2'h1
`define DMACC_REG_COUNT 2'h2
`define DMACC_REG_CTRL 2'h3

// Control register fields
`define DMACC_BIT_ENABLE 7
`define DMACC_BIT_SIZE 6
`define DMACC_BIT_DIR 5
`define DMACC_BIT_REPEAT 4
`define DMACC_BIT_ENDIE 3
`define DMACC_CTRL_RESET 8'h00

// Address forming
`define DMACC_TOP_BYTE 8'hFF
`define DMACC_IO_UPPER 24'hFF_FFFF
`define DMACC_STEP_BYTE 24'h00_0001
`define DMACC_STEP_WORD 24'h00_0002

`endif

// file: hdl/dmacc_pkg.sv
package dmacc_pkg;

   typedef logic [1:0] dmacc_ch_type;

   typedef enum logic [2:0] {
      SRC_TIMER0 = 3'b000,
      SRC_TIMER1 = 3'b001,
      SRC_TIMER2 = 3'b010,
      SRC_ADC_END = 3'b011,
      SRC_TX_EMPTY = 3'b100,
      SRC_RX_FULL = 3'b101,
      SRC_PIN_EDGE = 3'b110,
      SRC_PIN_LEVEL = 3'b111
   } dmacc_src_type;

   typedef enum logic [0:0] {
      ENG_IDLE = 1'b0,
      ENG_BUS = 1'b1
   } dmacc_eng_type;

endpackage

// file: hdl/dmacc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module dmacc_pin_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] pin_raw,
   output logic [1:0] pin_low,
   output logic [1:0] pin_fall
);
   import dmacc_pkg::*;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_pin
         logic s1_reg, s2_reg, s3_reg, level_reg, fall_reg;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_reg <= 1'b1;
               s2_reg <= 1'b1;
               s3_reg <= 1'b1;
            end else begin
               s1_reg <= pin_raw[g];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
            end
         end
         // Accept a change only once the last two stages agree
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               level_reg <= 1'b1;
               fall_reg <= 1'b0;
            end else begin
               fall_reg <= (s2_reg == s3_reg) && level_reg && !s3_reg;
               if (s2_reg == s3_reg) begin
                  level_reg <= s3_reg;
               end
            end
         end
         assign pin_low[g] = !level_reg;
         assign pin_fall[g] = fall_reg;
      end
   endgenerate

endmodule

`default_nettype wire

// file: hdl/dmacc_top.sv
// Notes on behaviour
// [RULE_01] I/O and idle: 16-bit count, end at zero
// [RULE_02] Repeat: high byte counts, reloads from low
// [RULE_03] Count registers not reset or cleared
// [RULE_04] Control cleared by reset and standby
// [RULE_05] Enabled channel transfers on its source only; the A half of a full-mode pair requests on every cycle instead
// [RULE_06] Enable sets only after read showing zero
// [RULE_07] I/O, idle clear enable at count end
// [RULE_08] End interrupt on enable clear when allowed
// [RULE_09] Size bit picks byte or word
// [RULE_10] Direction bit steps address by size
// [RULE_11] Idle mode keeps memory address fixed
// [RULE_12] Repeat and bit 3 select mode
// [RULE_13] Low three bits select activation source
// [RULE_14] Shared source serviced in fixed priority
// [RULE_15] Enabled channel masks its source's CPU interrupt
// [RULE_16] Full mode: A address source, B destination
// [RULE_17] Address top byte reads ones, ignores writes
// [RULE_18] Address register updated after every transfer except in idle mode
// [RULE_19] Address registers not reset or cleared
// [RULE_20] Receive and A/D sources write memory
// [RULE_21] I/O address upper bits ones, never stepped
// [RULE_22] Full mode only when A select bits 11
// [RULE_23] External request pin feeds B channels only
// [RULE_24] Count, address, enable update together at done
`timescale 1ns/1ps
`default_nettype none
`include "dmacc_consts.svh"

module dmacc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic standby_entry,
   input wire logic [2:0] timer_event,
   input wire logic adc_end_event,
   input wire logic serial_tx_empty,
   input wire logic serial_rx_full,
   input wire logic [1:0] external_request_pin,
   output logic [5:0] source_irq_out,
   output logic [3:0] transfer_end_interrupt,
   output logic bus_req,
   output logic [31:0] bus_src_addr,
   output logic [31:0] bus_dst_addr,
   output logic bus_word,
   input wire logic bus_done,
   output dmacc_pkg::dmacc_ch_type active_channel
);
   import dmacc_pkg::*;

   logic [7:0] ctrl_arr [4];
   logic [23:0] maddr_arr [4];
   logic [7:0] fixed_io_address_arr [4];
   logic [15:0] count_arr [4];
   logic [3:0] pend_vec;
   logic [3:0] full_vec;
   logic [5:0] events;
   logic [5:0] claim;
   logic [1:0] pin_low;
   logic [1:0] pin_fall;
   logic apb_access;
   logic apb_setup;
   logic [1:0] reg_sel;
   logic [1:0] ch_sel;
   logic unmapped;
   dmacc_eng_type eng_reg;
   dmacc_ch_type sel_reg;
   logic bus_req_reg;
   logic [31:0] src_reg;
   logic [31:0] dst_reg;
   logic word_reg;
   logic [31:0] prdata_reg;
   logic grant_any;
   dmacc_ch_type grant_ch;
   logic done_fire;
   logic [7:0] g_ctrl;
   logic g_full;
   logic [31:0] g_mem;
   logic [31:0] g_io;
   logic [31:0] g_partner;

   assign events = {serial_rx_full, serial_tx_empty, adc_end_event, timer_event};
   assign apb_setup = psel && !penable;
   assign apb_access = psel && penable;
   assign reg_sel = paddr[`DMACC_REG_LSB +: 2];
   assign ch_sel = paddr[`DMACC_CH_LSB +: 2];
   assign unmapped = (paddr[11:`DMACC_MAP_TOP] != 6'h00) || (paddr[1:0] != 2'h0);
   assign pready = 1'b1;
   assign pslverr = apb_access && unmapped;
   assign prdata = prdata_reg;
   assign done_fire = (eng_reg == ENG_BUS) && bus_done;

   dmacc_pin_sync u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_raw(external_request_pin),
      .pin_low(pin_low),
      .pin_fall(pin_fall)
   );

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gen_ch
         localparam int PAIR = g / 2;
         localparam bit SIDE_B = (g % 2) == 1;
         logic [7:0] ctrl_reg;
         logic arm_reg;
         logic en_d_reg;
         logic endf_reg;
         logic pend_reg;
         logic [23:0] maddr_reg;
         logic [7:0] fixed_io_address_reg;
         logic [15:0] count_reg;
         logic pair_full;
         logic trig;
         logic own_done;
         logic step_done;
         logic is_repeat;
         logic is_idle;
         logic hw_clr;
         logic wr_hit;
         logic [23:0] step;
         logic [7:0] step_ctrl;

         assign wr_hit = apb_access && pwrite && !unmapped && (ch_sel == 2'(g));
         // Full mode is decided by the A half of the pair only
         assign pair_full = (ctrl_arr[PAIR*2][2:1] == 2'b11); // [RULE_22]
         assign is_repeat = !pair_full && ctrl_reg[`DMACC_BIT_REPEAT]
                            && !ctrl_reg[`DMACC_BIT_ENDIE]; // [RULE_12]
         assign is_idle = !pair_full && ctrl_reg[`DMACC_BIT_REPEAT]
                          && ctrl_reg[`DMACC_BIT_ENDIE]; // [RULE_12]
         assign own_done = done_fire && (sel_reg == 2'(g));
         // B address also walks when its pair runs in full mode
         assign step_done = own_done || (SIDE_B && pair_full && done_fire
                                         && (sel_reg == 2'(g - 1)));
         assign step_ctrl = SIDE_B && pair_full ? ctrl_arr[PAIR*2] : ctrl_reg;
         assign step = step_ctrl[`DMACC_BIT_SIZE] ? `DMACC_STEP_WORD
                                                   : `DMACC_STEP_BYTE; // [RULE_10]
         // End of an I/O or idle sequence drops the enable
         assign hw_clr = own_done && !is_repeat && (count_reg == 16'h0001); // [RULE_07]

         always_comb begin
            trig = 1'b0;
            if (SIDE_B && pair_full) begin
               trig = 1'b0;
            end else if (!SIDE_B && pair_full) begin
               trig = 1'b1;
            end else if (ctrl_reg[2:0] == SRC_PIN_EDGE) begin
               trig = SIDE_B && pin_fall[PAIR]; // [RULE_23]
            end else if (ctrl_reg[2:0] == SRC_PIN_LEVEL) begin
               trig = SIDE_B && pin_low[PAIR]; // [RULE_23]
            end else begin
               trig = events[ctrl_reg[2:0]]; // [RULE_13]
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ctrl_reg <= `DMACC_CTRL_RESET;
               arm_reg <= 1'b0;
            end else if (standby_entry) begin
               ctrl_reg <= `DMACC_CTRL_RESET; // [RULE_04]
               arm_reg <= 1'b0;
            end else if (wr_hit && reg_sel == `DMACC_REG_CTRL) begin
               ctrl_reg <= {pwdata[`DMACC_BIT_ENABLE] && (ctrl_reg[`DMACC_BIT_ENABLE]
                            || arm_reg), pwdata[6:0]}; // [RULE_06]
               arm_reg <= 1'b0;
            end else begin
               if (hw_clr) begin
                  ctrl_reg[`DMACC_BIT_ENABLE] <= 1'b0; // [RULE_24]
               end
               if (apb_access && !pwrite && !unmapped && ch_sel == 2'(g)
                   && reg_sel == `DMACC_REG_CTRL && !ctrl_reg[`DMACC_BIT_ENABLE]) begin
                  arm_reg <= 1'b1; // [RULE_06]
               end
            end
         end

         // Sticky end flag; a new end beats a clearing write
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               en_d_reg <= 1'b0;
               endf_reg <= 1'b0;
            end else begin
               en_d_reg <= ctrl_reg[`DMACC_BIT_ENABLE];
               if (en_d_reg && !ctrl_reg[`DMACC_BIT_ENABLE]
                   && ctrl_reg[`DMACC_BIT_ENDIE]) begin
                  endf_reg <= 1'b1; // [RULE_08]
               end else if (wr_hit && reg_sel == `DMACC_REG_CTRL) begin
                  endf_reg <= 1'b0;
               end
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pend_reg <= 1'b0;
            end else if (!ctrl_reg[`DMACC_BIT_ENABLE] || hw_clr) begin
               // A held level request must not outlive the final transfer
               pend_reg <= 1'b0; // [RULE_05]
            end else if (trig) begin
               pend_reg <= 1'b1; // [RULE_05]
            end else if (own_done) begin
               pend_reg <= 1'b0;
            end
         end

         // No reset: contents stay undefined until software writes them
         always_ff @(posedge pclk) begin
            if (wr_hit && reg_sel == `DMACC_REG_COUNT) begin
               count_reg <= pwdata[15:0]; // [RULE_03]
            end else if (own_done && is_repeat) begin
               if (count_reg[15:8] == 8'h01) begin
                  count_reg[15:8] <= count_reg[7:0]; // [RULE_02]
               end else begin
                  count_reg[15:8] <= count_reg[15:8] - 8'h01; // [RULE_02]
               end
            end else if (own_done) begin
               count_reg <= count_reg - 16'h0001; // [RULE_01]
            end
         end

         always_ff @(posedge pclk) begin
            if (wr_hit && reg_sel == `DMACC_REG_MADDR) begin
               maddr_reg <= pwdata[23:0]; // [RULE_19]
            end else if (step_done && !is_idle) begin // [RULE_11]
               if (step_ctrl[`DMACC_BIT_DIR]) begin
                  maddr_reg <= maddr_reg - step; // [RULE_18]
               end else begin
                  maddr_reg <= maddr_reg + step; // [RULE_10]
               end
            end
         end

         // Never stepped by transfers
         always_ff @(posedge pclk) begin
            if (wr_hit && reg_sel == `DMACC_REG_IOADDR) begin
               fixed_io_address_reg <= pwdata[7:0]; // [RULE_21]
            end
         end

         assign ctrl_arr[g] = ctrl_reg;
         assign maddr_arr[g] = maddr_reg;
         assign fixed_io_address_arr[g] = fixed_io_address_reg;
         assign count_arr[g] = count_reg;
         assign pend_vec[g] = pend_reg;
         assign full_vec[g] = pair_full;
         assign transfer_end_interrupt[g] = endf_reg;
      end
   endgenerate

   // An enabled channel owns its internal source
   always_comb begin
      claim = 6'h00;
      for (int c = 0; c < 4; c++) begin
         if (ctrl_arr[c][`DMACC_BIT_ENABLE] && !full_vec[c]
             && ctrl_arr[c][2:1] != 2'b11) begin
            claim[ctrl_arr[c][2:0]] = 1'b1; // [RULE_15]
         end
      end
   end
   assign source_irq_out = events & ~claim; // [RULE_15]

   // Lowest index wins
   always_comb begin
      grant_any = 1'b0;
      grant_ch = 2'h0;
      for (int c = 3; c >= 0; c--) begin
         if (pend_vec[c]) begin
            grant_any = 1'b1;
            grant_ch = 2'(c); // [RULE_14]
         end
      end
   end

   assign g_ctrl = ctrl_arr[grant_ch];
   assign g_full = full_vec[grant_ch];
   assign g_mem = {`DMACC_TOP_BYTE, maddr_arr[grant_ch]};
   assign g_io = {`DMACC_IO_UPPER, fixed_io_address_arr[grant_ch]}; // [RULE_21]
   assign g_partner = {`DMACC_TOP_BYTE, maddr_arr[grant_ch | 2'h1]};

   // Addresses frozen for the whole bus cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eng_reg <= ENG_IDLE;
         sel_reg <= 2'h0;
         bus_req_reg <= 1'b0;
         src_reg <= 32'h0000_0000;
         dst_reg <= 32'h0000_0000;
         word_reg <= 1'b0;
      end else begin
         unique case (eng_reg)
            ENG_IDLE: begin
               if (grant_any) begin
                  eng_reg <= ENG_BUS;
                  sel_reg <= grant_ch;
                  bus_req_reg <= 1'b1;
                  word_reg <= g_ctrl[`DMACC_BIT_SIZE]; // [RULE_09]
                  if (g_full) begin
                     src_reg <= g_mem; // [RULE_16]
                     dst_reg <= g_partner; // [RULE_16]
                  end else if (g_ctrl[2:0] == SRC_RX_FULL
                               || g_ctrl[2:0] == SRC_ADC_END) begin
                     src_reg <= g_io; // [RULE_20]
                     dst_reg <= g_mem;
                  end else begin
                     src_reg <= g_mem; // [RULE_20]
                     dst_reg <= g_io;
                  end
               end
            end
            ENG_BUS: begin
               if (bus_done) begin
                  eng_reg <= ENG_IDLE; // [RULE_24]
                  bus_req_reg <= 1'b0;
               end
            end
         endcase
      end
   end

   assign bus_req = bus_req_reg;
   assign bus_src_addr = src_reg;
   assign bus_dst_addr = dst_reg;
   assign bus_word = word_reg;
   assign active_channel = sel_reg;

   // Read data captured in setup so it is a flop in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (apb_setup) begin
         prdata_reg <= 32'h0000_0000;
         if (!unmapped) begin
            unique case (reg_sel)
               `DMACC_REG_MADDR: prdata_reg <= {`DMACC_TOP_BYTE, maddr_arr[ch_sel]}; // [RULE_17]
               `DMACC_REG_IOADDR: prdata_reg <= {24'h00_0000, fixed_io_address_arr[ch_sel]};
               `DMACC_REG_COUNT: prdata_reg <= {16'h0000, count_arr[ch_sel]};
               `DMACC_REG_CTRL: prdata_reg <= {24'h00_0000, ctrl_arr[ch_sel]};
            endcase
         end
      end
   end

   logic [7:0] s_ctrl;
   logic [15:0] s_cnt;
   logic [23:0] s_addr;
   logic [23:0] s_step;
   assign s_ctrl = ctrl_arr[sel_reg];
   assign s_step = s_ctrl[`DMACC_BIT_SIZE] ? 24'h00_0002 : 24'h00_0001;
   assign s_cnt = count_arr[sel_reg];
   assign s_addr = maddr_arr[sel_reg];

   count_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
      done_fire && !s_ctrl[`DMACC_BIT_REPEAT] && !full_vec[sel_reg]
      |=> count_arr[$past(sel_reg)] == $past(s_cnt) - 16'h0001)
      else $error("count did not drop by one"); // [RULE_01]

   repeat_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
      done_fire && s_ctrl[4:3] == 2'b10 && !full_vec[sel_reg] && s_cnt[15:8] == 8'h01
      |=> count_arr[$past(sel_reg)][15:8] == $past(s_cnt[7:0]))
      else $error("repeat count not reloaded"); // [RULE_02]

   ctrl_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      standby_entry |=> ctrl_arr[0] == 8'h00 && ctrl_arr[3] == 8'h00)
      else $error("control not cleared on standby"); // [RULE_04]

   req_enabled_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(bus_req) |-> ctrl_arr[sel_reg][`DMACC_BIT_ENABLE])
      else $error("transfer started on disabled channel"); // [RULE_05]

   end_disable_a: assert property (@(posedge pclk) disable iff (!presetn)
      done_fire && !(s_ctrl[4:3] == 2'b10 && !full_vec[sel_reg]) && s_cnt == 16'h0001
      && !(apb_access && pwrite) && !standby_entry
      |=> !ctrl_arr[$past(sel_reg)][`DMACC_BIT_ENABLE]
      ##1 !(bus_req && sel_reg == $past(sel_reg, 2)))
      else $error("enable not cleared at count end"); // [RULE_07]

   end_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(ctrl_arr[1][`DMACC_BIT_ENABLE]) && ctrl_arr[1][`DMACC_BIT_ENDIE]
      |=> transfer_end_interrupt[1])
      else $error("end interrupt missing"); // [RULE_08]

   word_size_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(bus_req) |-> bus_word == ctrl_arr[sel_reg][`DMACC_BIT_SIZE])
      else $error("transfer width wrong"); // [RULE_09]

   idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      done_fire && s_ctrl[4:3] == 2'b11 && !full_vec[sel_reg] && !(apb_access && pwrite)
      |=> maddr_arr[$past(sel_reg)] == $past(s_addr))
      else $error("idle mode moved the address"); // [RULE_11]

   addr_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      done_fire && s_ctrl[4:3] != 2'b11 && !full_vec[sel_reg] && !(apb_access && pwrite)
      |=> maddr_arr[$past(sel_reg)] == ($past(s_ctrl[`DMACC_BIT_DIR])
          ? $past(s_addr) - $past(s_step) : $past(s_addr) + $past(s_step)))
      else $error("address step wrong"); // [RULE_10]

   irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_arr[1][`DMACC_BIT_ENABLE] && ctrl_arr[1][2:0] == 3'b011 && !full_vec[1]
      |-> !source_irq_out[3])
      else $error("claimed source reached the CPU"); // [RULE_15]

endmodule

`default_nettype wire

// file: verif/dmacc_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

module dmacc_bus_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic bus_req,
   input wire logic [2:0] delay,
   output logic bus_done
);
   logic [2:0] wait_reg;

   // Done only while a request stands; delay 0 answers next cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_done <= 1'b0;
         wait_reg <= 3'h0;
      end else if (!bus_req || bus_done) begin
         bus_done <= 1'b0;
         wait_reg <= delay;
      end else if (wait_reg == 3'h0) begin
         bus_done <= 1'b1;
      end else begin
         wait_reg <= wait_reg - 3'h1;
      end
   end
endmodule

`default_nettype wire

// file: verif/dma_channel_count_and_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module dma_channel_count_and_control_test;
   import dmacc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, standby_entry;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat, bus_src_addr, bus_dst_addr, mem32, io32, m0, i0;
   logic [5:0] ev, source_irq_out;
   logic [1:0] pin;
   logic [3:0] transfer_end_interrupt;
   logic bus_req, bus_word, bus_done, perr, seen;
   logic [2:0] dly, sv;
   logic [23:0] ma;
   logic [7:0] io, ctl;
   dmacc_ch_type active_channel;
   logic [31:0] seed;
   int bad_count, samples_checked, cyc;

   dmacc_top dmacc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .standby_entry(standby_entry), .timer_event(ev[2:0]),
      .adc_end_event(ev[3]), .serial_tx_empty(ev[4]), .serial_rx_full(ev[5]),
      .external_request_pin(pin), .source_irq_out(source_irq_out),
      .transfer_end_interrupt(transfer_end_interrupt), .bus_req(bus_req),
      .bus_src_addr(bus_src_addr), .bus_dst_addr(bus_dst_addr), .bus_word(bus_word),
      .bus_done(bus_done), .active_channel(active_channel));
   dmacc_bus_model dmacc_bus_model_i (.pclk(pclk), .presetn(presetn), .bus_req(bus_req),
      .delay(dly), .bus_done(bus_done));

   initial pclk = 1'b0;
   always #50 pclk = ~pclk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [11:0] ra(input int ch, input int r);
      return 12'(ch * 16 + r * 4);
   endfunction

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end

   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, got);
      end
   endtask

   // Request held until pready sampled high, released at that edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic setup(input int ch, input logic [15:0] cnt, input logic [7:0] c);
      ma = 24'(rnd());
      io = 8'(rnd());
      mem32 = {8'hFF, ma};
      io32 = {24'hFF_FFFF, io};
      apb(1'b1, ra(ch, 0), 32'(ma));
      apb(1'b1, ra(ch, 1), 32'(io));
      apb(1'b1, ra(ch, 2), 32'(cnt));
      apb(1'b0, ra(ch, 3), 32'h0000_0000);
      apb(1'b1, ra(ch, 3), 32'(c));
   endtask

   task automatic fire(input int s, input logic en);
      @(posedge pclk);
      if (s < 6) begin
         ev <= 6'(1 << s);
         #1;
         chk("irq_pass", 32'(source_irq_out[s]), 32'(!en));
         @(posedge pclk);
         ev <= 6'h00;
      end else begin
         pin <= 2'b10;
      end
   endtask

   task automatic xfer(input logic [31:0] s, input logic [31:0] d, input logic w);
      dly <= 3'(rnd());
      while (bus_req !== 1'b1) @(posedge pclk);
      chk("src", bus_src_addr, s);
      chk("dst", bus_dst_addr, d);
      chk("word", 32'(bus_word), 32'(w));
      while (bus_req === 1'b1) @(posedge pclk);
   endtask

   initial begin
      {psel, penable, pwrite, standby_entry, dly, ev, paddr, pwdata} = '0;
      pin = 2'b11;
      presetn = 1'b0;
      seed = 32'h0000_0063;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int ch = 0; ch < 4; ch++) begin
         apb(1'b0, ra(ch, 3), 32'h0000_0000);
         chk("ctrl_reset", rdat, 32'h0000_0000);
      end
      apb(1'b1, ra(0, 0), 32'h1234_5678);
      apb(1'b0, ra(0, 0), 32'h0000_0000);
      chk("maddr_top", rdat, 32'hFF34_5678);
      apb(1'b0, 12'h040, 32'h0000_0000);
      chk("unmapped", {perr, rdat[30:0]}, 32'h8000_0000);
      // Every activation code on a B half, odd codes with bit 3 set
      for (int s = 0; s < 8; s++) begin
         sv = 3'(s);
         ctl = {4'h8, sv[0], sv};
         setup(1, 16'h0001, ctl);
         fire(s, 1'b1);
         if (s == 3 || s == 5) xfer(io32, mem32, 1'b0);
         else xfer(mem32, io32, 1'b0);
         pin <= 2'b11;
         repeat (2) @(posedge pclk);
         apb(1'b0, ra(1, 3), 32'h0000_0000);
         chk("ctrl_end", rdat, 32'(ctl[6:0]));
         chk("end_irq", 32'(transfer_end_interrupt[1]), 32'(sv[0]));
         apb(1'b0, ra(1, 2), 32'h0000_0000);
         chk("count_end", rdat, 32'h0000_0000);
         apb(1'b0, ra(1, 0), 32'h0000_0000);
         chk("maddr_step", rdat, {8'hFF, ma + 24'h00_0001});
      end
      // Repeat mode, words, stepping down
      setup(0, 16'h0202, 8'hF2);
      for (int k = 0; k < 3; k++) begin
         fire(2, 1'b1);
         xfer({8'hFF, ma - 24'(2 * k)}, io32, 1'b1);
      end
      repeat (2) @(posedge pclk);
      apb(1'b0, ra(0, 3), 32'h0000_0000);
      chk("repeat_ctrl", rdat, 32'h0000_00F2);
      apb(1'b0, ra(0, 2), 32'h0000_0000);
      chk("repeat_count", rdat, 32'h0000_0102);
      apb(1'b1, ra(0, 3), 32'h0000_0000);
      // Idle mode keeps the memory address
      setup(2, 16'h0002, 8'h9B);
      for (int k = 0; k < 2; k++) begin
         fire(3, 1'b1);
         xfer(io32, mem32, 1'b0);
      end
      repeat (2) @(posedge pclk);
      apb(1'b0, ra(2, 3), 32'h0000_0000);
      chk("idle_ctrl", rdat, 32'h0000_001B);
      chk("idle_irq", 32'(transfer_end_interrupt[2]), 32'h0000_0001);
      apb(1'b0, ra(2, 0), 32'h0000_0000);
      chk("idle_maddr", rdat, mem32);
      // Shared source: lower channel number goes first
      setup(0, 16'h0001, 8'h81);
      m0 = mem32;
      i0 = io32;
      setup(2, 16'h0001, 8'h81);
      fire(1, 1'b1);
      xfer(m0, i0, 1'b0);
      xfer(mem32, io32, 1'b0);
      chk("last_channel", 32'(active_channel), 32'h0000_0002);
      // Disabled channel ignores its source
      fire(0, 1'b0);
      seen = 1'b0;
      repeat (8) @(posedge pclk) if (bus_req === 1'b1) seen = 1'b1;
      chk("no_request", 32'(seen), 32'h0000_0000);
      // Enable needs a preceding read; standby clears control only
      apb(1'b1, ra(3, 2), 32'h0000_ABCD);
      // The reset-time read armed this channel; a control write disarms it
      apb(1'b1, ra(3, 3), 32'h0000_0000);
      apb(1'b1, ra(3, 3), 32'h0000_0080);
      apb(1'b0, ra(3, 3), 32'h0000_0000);
      chk("enable_refused", rdat, 32'h0000_0000);
      apb(1'b1, ra(3, 3), 32'h0000_0084);
      apb(1'b0, ra(3, 3), 32'h0000_0000);
      chk("enable_taken", rdat, 32'h0000_0084);
      @(posedge pclk);
      standby_entry <= 1'b1;
      @(posedge pclk);
      standby_entry <= 1'b0;
      apb(1'b0, ra(3, 3), 32'h0000_0000);
      chk("standby_ctrl", rdat, 32'h0000_0000);
      apb(1'b0, ra(3, 2), 32'h0000_0000);
      chk("standby_count", rdat, 32'h0000_ABCD);
      report_and_stop();
   end
endmodule

`default_nettype wire
